// ---- logic/stres_pkg.sv ----
// Package with register map, field layout and configuration codes for the selftest result block
package stres_pkg;

    // ********************************
    // Register offsets (byte addresses)
    // ********************************
    localparam logic [11:0] STRES_OFF_RECORD  = 12'h000;
    localparam logic [11:0] STRES_OFF_READCMD = 12'h004;
    localparam logic [11:0] STRES_OFF_CONFIG  = 12'h008;
    localparam logic [11:0] STRES_OFF_INPORT  = 12'h00c;
    localparam logic [11:0] STRES_OFF_CTRL    = 12'h010;

    // ********************************
    // Record layout
    // ********************************
    localparam int STRES_BIT_ERR      = 15;
    localparam int STRES_BIT_ZERO_HI  = 14;
    localparam int STRES_UNIT_LSB     = 12;
    localparam int STRES_BIT_ZERO_LO  = 11;
    localparam int STRES_HEAD_LSB     = 8;
    localparam int STRES_CODE_LSB     = 0;
    localparam logic [15:0] STRES_RECORD_RST = 16'h0000;

    // ********************************
    // Input port layout
    // ********************************
    localparam int STRES_IN_CAP_BIT = 5;
    localparam int STRES_IN_VOL_BIT = 4;
    localparam int STRES_IN_FAM_BIT = 3;

    // ********************************
    // Sources of a captured error
    // ********************************
    localparam int STRES_NSRC = 3;
    localparam int STRES_SRC_POWERON  = 0;
    localparam int STRES_SRC_INITIATE = 1;
    localparam int STRES_SRC_RUNTIME  = 2;

    // Last settle count before the filtered jumper levels are trusted
    localparam logic [2:0] STRES_SETTLE_LAST = 3'h4;

    // ********************************
    // Decoded drive configuration
    // ********************************
    typedef enum logic [2:0] {
        STRES_CFG_INVALID,
        STRES_CFG_SP5_FOURVOL,
        STRES_CFG_SP5_ONEVOL,
        STRES_CFG_DP10_ONEVOL
    } stres_cfg_t;

    localparam logic [1:0] STRES_VOLS_FOUR = 2'h3;
    localparam logic [1:0] STRES_VOLS_ONE  = 2'h0;

    // Volume sizes in units of 10 kbyte
    localparam logic [9:0] STRES_SIZE_FOURVOL = 10'h073;
    localparam logic [9:0] STRES_SIZE_SP5_ONE = 10'h1e0;
    localparam logic [9:0] STRES_SIZE_DP10    = 10'h3e8;
    localparam logic [9:0] STRES_SIZE_NONE    = 10'h000;

    localparam logic [31:0] STRES_DATA_ZERO = 32'h0000_0000;

endpackage : stres_pkg

// ---- logic/stres_sync.sv ----
// Three-stage synchroniser with agreement filter for a bank of pins
`timescale 1ns/10ps
module stres_sync
    import stres_pkg::*;
#(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Pins and filtered levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } stres_sync_state_t;

    stres_sync_state_t st_reg;
    stres_sync_state_t st_next;

    genvar gi;
    logic [W-1:0] agree;
    // First stage feeds only the second stage
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            assign agree[gi] = (st_reg.s2[gi] == st_reg.s3[gi]);
        end
    endgenerate

    always_comb begin
        st_next     = st_reg;
        st_next.s1  = pin_in;
        st_next.s2  = st_reg.s1;
        st_next.s3  = st_reg.s2;
        st_next.lvl = (st_reg.s2 & agree) | (st_reg.lvl & ~agree);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.lvl;

endmodule : stres_sync

// ---- logic/stres_top.sv ----
// Selftest result record and configuration jumper decode with an APB register port
`timescale 1ns/10ps

// Summary of operation
// [R1] Two-byte record holds latest error, overwriting
// [R2] Read command returns record then clears it
// [R3] Top bit error flag; two fixed zeros
// [R4] Unit field follows leading zero
// [R5] Low three bits hold selected head
// [R6] Second byte holds failure code
// [R7] Flag clear means both bytes zero
// [R8] Power-on and initiate tests share record
// [R9] Runtime check failures update the record
// [R10] No cap, no onevol, family: four volumes
// [R11] Onevol and family only: one small volume
// [R12] All three jumpers: one large volume
// [R13] Other five combinations flagged invalid
// [R14] Jumpers readable on input port bits 5,4,3
// [R15] Jumpers sampled once after reset, held
module stres_top
    import stres_pkg::*;
(
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Error reports from the test sequencers and runtime checks
    input  wire logic [2:0]  err_valid,
    input  wire logic [5:0]  err_unit,
    input  wire logic [8:0]  err_head,
    input  wire logic [23:0] err_code,
    // Configuration jumper pins, low when installed
    input  wire logic        jumper_capacity_n,
    input  wire logic        jumper_one_volume_n,
    input  wire logic        jumper_family_n,
    // Decoded configuration
    output logic [2:0]       cfg_layout,
    output logic [1:0]       cfg_extra_volumes,
    output logic [9:0]       cfg_volume_size,
    output logic             cfg_invalid,
    output logic             cfg_valid,
    // Diagnostic record as seen by the host bus logic
    output logic [15:0]      diag_record,
    output logic             diag_read_done
);

    // ********************************
    // State
    // ********************************
    // Record fields stay zero whenever the flag is clear, so no masking is needed later
    typedef struct packed {
        logic        err;
        logic [1:0]  unit;
        logic [2:0]  head;
        logic [7:0]  code;
        logic [15:0] rec;
        logic [2:0]  jmp;
        logic        jmp_taken;
        logic [2:0]  settle;
        stres_cfg_t  cfg;
        logic [1:0]  vols;
        logic [9:0]  size;
        logic        cfg_ok;
        logic        cfg_bad;
        logic [2:0]  src_last;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        read_done;
    } stres_state_t;

    stres_state_t st_reg;
    stres_state_t st_next;

    // ********************************
    // Jumper synchroniser
    // ********************************
    logic [2:0] jmp_pins;
    logic [2:0] jmp_lvl;

    // Pins are active low on the header, inverted so 1 means installed
    assign jmp_pins = {~jumper_capacity_n, ~jumper_one_volume_n, ~jumper_family_n};
    // Only the filtered levels are used; the raw pins never reach the decode

    stres_sync #(.W(3)) u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (jmp_pins),
        .level_out (jmp_lvl)
    );

    // ********************************
    // Error source selection
    // ********************************
    // Runtime checks have the highest index and win a same-cycle tie
    logic       any_err;
    logic [1:0] sel_unit;
    logic [2:0] sel_head;
    logic [7:0] sel_code;
    logic [1:0] src_unit [STRES_NSRC];
    logic [2:0] src_head [STRES_NSRC];
    logic [7:0] src_code [STRES_NSRC];

    // Each source owns its own slice of the packed report buses
    genvar si;
    generate
        for (si = 0; si < STRES_NSRC; si++) begin : g_src
            assign src_unit[si] = err_unit[2*si +: 2];
            assign src_head[si] = err_head[3*si +: 3];
            assign src_code[si] = err_code[8*si +: 8];
        end
    endgenerate

    always_comb begin
        any_err  = 1'b0;
        sel_unit = 2'h0;
        sel_head = 3'h0;
        sel_code = 8'h00;
        for (int i = 0; i < STRES_NSRC; i++) begin
            if (err_valid[i]) begin // R8 R9
                any_err  = 1'b1;
                sel_unit = src_unit[i];
                sel_head = src_head[i];
                sel_code = src_code[i];
            end
        end
    end

    // ********************************
    // Register view helpers
    // ********************************
    logic [15:0] rec_view;
    logic [7:0]  in_port;
    logic        acc;
    logic        wr_acc;
    logic        rd_cmd;
    logic        rd_acc;
    logic        bad_acc;
    logic        hit_record;
    logic        hit_readcmd;
    logic        hit_config;
    logic        hit_inport;
    logic        hit_ctrl;
    logic        hit_any;

    always_comb begin
        rec_view = STRES_RECORD_RST;
        if (st_reg.err) begin // R7
            rec_view[STRES_BIT_ERR]                 = 1'b1; // R3
            rec_view[STRES_BIT_ZERO_HI]             = 1'b0; // R3
            rec_view[STRES_UNIT_LSB +: 2]           = st_reg.unit; // R4
            rec_view[STRES_BIT_ZERO_LO]             = 1'b0; // R3
            rec_view[STRES_HEAD_LSB +: 3]           = st_reg.head; // R5
            rec_view[STRES_CODE_LSB +: 8]           = st_reg.code; // R6
        end
    end

    // ********************************
    // Input port image
    // ********************************
    // The processor sees the captured jumpers, not the live pins
    always_comb begin
        in_port = 8'h00;
        in_port[STRES_IN_CAP_BIT] = st_reg.jmp[2]; // R14
        in_port[STRES_IN_VOL_BIT] = st_reg.jmp[1]; // R14
        in_port[STRES_IN_FAM_BIT] = st_reg.jmp[0]; // R14
    end

    assign acc    = psel && penable && !st_reg.ready;
    assign wr_acc = acc && pwrite;
    assign rd_acc = acc && !pwrite;
    assign rd_cmd = wr_acc && hit_readcmd && pstrb[0] && pwdata[0];

    // ********************************
    // Address decode
    // ********************************
    // Offsets compare in full, so aliases of a word are refused
    assign hit_record  = (paddr == STRES_OFF_RECORD);
    assign hit_readcmd = (paddr == STRES_OFF_READCMD);
    assign hit_config  = (paddr == STRES_OFF_CONFIG);
    assign hit_inport  = (paddr == STRES_OFF_INPORT);
    assign hit_ctrl    = (paddr == STRES_OFF_CTRL);
    assign hit_any     = hit_record || hit_readcmd || hit_config ||
                         hit_inport || hit_ctrl;
    // Refused accesses answer with an error and change no state
    assign bad_acc     = (rd_acc && !hit_any) || (wr_acc && !hit_readcmd);

    // ********************************
    // Jumper decode
    // ********************************
    // Decoded from the filtered levels every cycle, but latched only once
    stres_cfg_t dec_cfg;
    logic [1:0] dec_vols;
    logic [9:0] dec_size;
    logic       dec_ok;

    always_comb begin
        dec_cfg  = STRES_CFG_INVALID;
        dec_vols = STRES_VOLS_ONE;
        dec_size = STRES_SIZE_NONE;
        dec_ok   = 1'b0;
        case (jmp_lvl)
            3'h1: begin
                dec_cfg  = STRES_CFG_SP5_FOURVOL; // R10
                dec_vols = STRES_VOLS_FOUR; // R10
                dec_size = STRES_SIZE_FOURVOL; // R10
                dec_ok   = 1'b1;
            end
            3'h3: begin
                dec_cfg  = STRES_CFG_SP5_ONEVOL; // R11
                dec_size = STRES_SIZE_SP5_ONE; // R11
                dec_ok   = 1'b1;
            end
            3'h7: begin
                // Dual platter has no four volume mode
                dec_cfg  = STRES_CFG_DP10_ONEVOL; // R12
                dec_size = STRES_SIZE_DP10; // R12
                dec_ok   = 1'b1;
            end
            3'h0, 3'h2, 3'h4, 3'h5, 3'h6: begin
                // Unassigned: never fall back onto a real layout
                dec_cfg  = STRES_CFG_INVALID; // R13
                dec_ok   = 1'b0; // R13
            end
            default: begin
                dec_cfg  = STRES_CFG_INVALID; // R13
            end
        endcase
    end

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        st_next           = st_reg;
        st_next.ready     = acc;
        st_next.slverr    = 1'b0;
        st_next.read_done = 1'b0;
        st_next.rdata     = STRES_DATA_ZERO;

        // Read command: the record is returned in the same beat, then cleared
        if (rd_cmd) begin // R2
            st_next.rdata     = {16'h0000, rec_view}; // R2
            st_next.err       = 1'b0; // R2
            st_next.unit      = 2'h0; // R2
            st_next.head      = 3'h0; // R2
            st_next.code      = 8'h00; // R2
            st_next.read_done = 1'b1;
        end

        // A new error lands after the clear, so one arriving together is kept
        if (any_err) begin // R1
            st_next.err      = 1'b1; // R1
            st_next.unit     = sel_unit; // R1
            st_next.head     = sel_head; // R1
            st_next.code     = sel_code; // R1
            st_next.src_last = err_valid;
        end

        // Jumpers are taken once after the synchroniser has settled
        if (!st_reg.jmp_taken) begin // R15
            // The filter needs four edges after reset before its level follows a set pin
            if (st_reg.settle != STRES_SETTLE_LAST) begin
                st_next.settle = st_reg.settle + 3'h1;
            end else begin
                st_next.jmp       = jmp_lvl; // R15
                st_next.jmp_taken = 1'b1; // R15
                st_next.cfg       = dec_cfg;
                st_next.vols      = dec_vols;
                st_next.size      = dec_size;
                st_next.cfg_ok    = dec_ok;
                st_next.cfg_bad   = !dec_ok; // R13
            end
        end

        // APB read data
        if (rd_acc) begin
            case (1'b1)
                hit_record: st_next.rdata = {16'h0000, rec_view};
                hit_config: st_next.rdata = {16'h0000, st_reg.size, st_reg.vols,
                                             st_reg.cfg_ok, st_reg.cfg};
                hit_inport: st_next.rdata = {24'h000000, in_port}; // R14
                hit_ctrl:   st_next.rdata = {29'h0, st_reg.src_last};
                default:    st_next.rdata = STRES_DATA_ZERO;
            endcase
        end
        // Only the read command port accepts writes
        st_next.slverr = bad_acc;

        // Registered copy of the visible record, so the port has no logic behind it
        st_next.rec = STRES_RECORD_RST;
        if (st_next.err) begin // R7
            st_next.rec[STRES_BIT_ERR]       = 1'b1; // R3
            st_next.rec[STRES_BIT_ZERO_HI]   = 1'b0; // R3
            st_next.rec[STRES_UNIT_LSB +: 2] = st_next.unit; // R4
            st_next.rec[STRES_BIT_ZERO_LO]   = 1'b0; // R3
            st_next.rec[STRES_HEAD_LSB +: 3] = st_next.head; // R5
            st_next.rec[STRES_CODE_LSB +: 8] = st_next.code; // R6
        end
    end

    // ********************************
    // Registers
    // ********************************
    // Reset leaves every field zero, which doubles as the invalid layout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg     <= '0;
            st_reg.cfg <= STRES_CFG_INVALID;
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    // Every output is a plain state bit, no logic after the flops
    assign prdata            = st_reg.rdata;
    assign pready            = st_reg.ready;
    assign pslverr           = st_reg.slverr;
    assign cfg_layout        = st_reg.cfg;
    assign cfg_extra_volumes = st_reg.vols;
    assign cfg_volume_size   = st_reg.size;
    assign cfg_invalid       = st_reg.cfg_bad;
    assign cfg_valid         = st_reg.cfg_ok;
    assign diag_read_done    = st_reg.read_done;
    assign diag_record       = st_reg.rec;

endmodule : stres_top

// ---- verif/stres_top_sva.sv ----
// Checker for the selftest record and jumper decode
`timescale 1ns/10ps
module stres_top_sva
    import stres_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Watched ports
    input wire logic [2:0]  err_valid,
    input wire logic [2:0]  cfg_layout,
    input wire logic [1:0]  cfg_extra_volumes,
    input wire logic [9:0]  cfg_volume_size,
    input wire logic        cfg_invalid,
    input wire logic        cfg_valid,
    input wire logic [15:0] diag_record,
    input wire logic        diag_read_done
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_idle; !diag_record[15] |-> diag_record == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("residue with flag clear");
    property p_zero; diag_record[14] == 1'b0 && diag_record[11] == 1'b0; endproperty
    a_zero: assert property (p_zero) else $error("fixed zero bit set");
    // A new error in the read cycle may win, so only quiet reads must clear
    property p_clear;
        diag_read_done && err_valid == 3'h0 && $past(err_valid) == 3'h0 |-> ##[0:1] diag_record == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("record kept after read");
    property p_four;
        cfg_layout == 3'h1 |-> cfg_extra_volumes == STRES_VOLS_FOUR && cfg_volume_size == 10'h073 && cfg_valid;
    endproperty
    a_four: assert property (p_four) else $error("four volume decode");
    property p_one; cfg_layout == 3'h2 |-> cfg_extra_volumes == 2'h0 && cfg_volume_size == 10'h1e0; endproperty
    a_one: assert property (p_one) else $error("one volume decode");
    property p_dual; cfg_layout == 3'h3 |-> cfg_extra_volumes == 2'h0 && cfg_volume_size == 10'h3e8; endproperty
    a_dual: assert property (p_dual) else $error("dual platter decode");
    property p_bad; cfg_invalid |-> !cfg_valid && cfg_layout == 3'h0 && cfg_volume_size == 10'h000; endproperty
    a_bad: assert property (p_bad) else $error("invalid mapped to layout");
    property p_hold; $past(cfg_valid) |-> cfg_valid && $stable(cfg_layout) && $stable(cfg_volume_size); endproperty
    a_hold: assert property (p_hold) else $error("config moved after capture");
    c_read: cover property (diag_read_done);
    c_err: cover property (diag_record[15]);
    c_bad: cover property (cfg_invalid);
endmodule : stres_top_sva

bind stres_top stres_top_sva u_stres_top_sva (
    .pclk(pclk), .presetn(presetn), .err_valid(err_valid), .cfg_layout(cfg_layout),
    .cfg_extra_volumes(cfg_extra_volumes), .cfg_volume_size(cfg_volume_size),
    .cfg_invalid(cfg_invalid), .cfg_valid(cfg_valid), .diag_record(diag_record),
    .diag_read_done(diag_read_done));

// ---- verif/stres_host_model.sv ----
// Behavioural host issuing bus transfers to the record block
`timescale 1ns/10ps
module stres_host_model (
    // Clock
    input wire logic        pclk,
    // Bus master side
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [11:0]     paddr,
    output logic [31:0]     pwdata,
    output logic [3:0]      pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // Holds the request until pready is seen; no fixed latency assumed
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : xfer
endmodule : stres_host_model

// ---- verif/testbench.sv ----
// Self-checking bench for the selftest record block
`timescale 1ns/10ps
`define CHK(g, x, m) begin checked++; if ((g) !== (x)) begin fail_count++; $display("[FAIL] %0t %s", $time, m); end end
module testbench
    import stres_pkg::*;
;
    // ********
    // Signals
    // ********
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, exp_cfg;
    logic [3:0]  pstrb;
    logic [2:0]  err_valid, jmp_n, cfg_layout;
    logic [5:0]  err_unit;
    logic [8:0]  err_head;
    logic [23:0] err_code;
    logic [1:0]  cfg_extra_volumes;
    logic [9:0]  cfg_volume_size;
    logic        cfg_invalid, cfg_valid, diag_read_done;
    logic [15:0] exp_rec;
    int          fail_count = 0;
    int          checked = 0;
    logic [2:0]  lay_tab [8] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h3};
    logic [9:0]  sz_tab [8] = '{10'h0, 10'h073, 10'h0, 10'h1e0, 10'h0, 10'h0, 10'h0, 10'h3e8};
    logic [15:0] diag_record;

    stres_top u_stres_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .err_valid(err_valid), .err_unit(err_unit),
        .err_head(err_head), .err_code(err_code), .jumper_capacity_n(jmp_n[2]),
        .jumper_one_volume_n(jmp_n[1]), .jumper_family_n(jmp_n[0]), .cfg_layout(cfg_layout),
        .cfg_extra_volumes(cfg_extra_volumes), .cfg_volume_size(cfg_volume_size),
        .cfg_invalid(cfg_invalid), .cfg_valid(cfg_valid), .diag_record(diag_record),
        .diag_read_done(diag_read_done));
    stres_host_model u_stres_host_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // ********
    // Tasks
    // ********
    task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
        u_stres_host_model.xfer(w, a, d, r, e);
    endtask : rw
    // Jumpers are set during reset since they are taken only once after it
    task automatic do_reset(input logic [2:0] inst);
        @(posedge pclk);
        presetn <= 1'b0;
        jmp_n   <= ~inst;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
    endtask : do_reset
    task automatic inject(input int s, input logic [1:0] u, input logic [2:0] h, input logic [7:0] c);
        logic [5:0]  fu;
        logic [8:0]  fh;
        logic [23:0] fc;
        {fu, fh, fc} = '0;
        fu[2*s +: 2] = u;
        fh[3*s +: 3] = h;
        fc[8*s +: 8] = c;
        @(posedge pclk);
        err_valid <= 3'(1 << s);
        {err_unit, err_head, err_code} <= {fu, fh, fc};
        @(posedge pclk);
        err_valid <= 3'h0;
        {err_unit, err_head, err_code} <= ~{fu, fh, fc};
    endtask : inject
    task automatic report_and_stop();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // ********
    // Stimulus
    // ********
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (6000) @(posedge pclk);
        fail_count++;
        $display("[FAIL] %0t timeout", $time);
        report_and_stop();
    end
    initial begin
        presetn = 1'b0;
        jmp_n = 3'h7;
        {err_valid, err_unit, err_head, err_code} = '0;
        for (int k = 0; k < 8; k++) begin
            do_reset(3'(k));
            `CHK(cfg_layout, lay_tab[k], "layout")
            `CHK(cfg_volume_size, sz_tab[k], "size")
            `CHK(cfg_extra_volumes, (k == 1) ? 2'h3 : 2'h0, "volumes")
            `CHK({cfg_valid, cfg_invalid}, (lay_tab[k] == 3'h0) ? 2'b01 : 2'b10, "valid")
            exp_cfg = {16'h0000, sz_tab[k], (k == 1) ? STRES_VOLS_FOUR : STRES_VOLS_ONE, lay_tab[k] != 3'h0, lay_tab[k]};
            rw(1'b0, STRES_OFF_CONFIG, 32'h0);
            `CHK(r, exp_cfg, "config word")
            rw(1'b0, STRES_OFF_INPORT, 32'h0);
            `CHK(r, 32'(k) << STRES_IN_FAM_BIT, "input port")
            jmp_n <= 3'(k);
            repeat (10) @(posedge pclk);
            `CHK(cfg_layout, lay_tab[k], "held")
        end
        $display("config test done");
        rw(1'b0, STRES_OFF_RECORD, 32'h0);
        `CHK(r, 32'h0, "record after reset")
        for (int s = 0; s < 3; s++) begin
            exp_rec = {2'b10, 2'(s + 1), 1'b0, 3'(s + 5), 8'h3c + 8'(s)};
            inject(s, exp_rec[13:12], exp_rec[10:8], exp_rec[7:0]);
            repeat (4) @(posedge pclk);
            rw(1'b0, STRES_OFF_RECORD, 32'h0);
            `CHK(r[15:0], exp_rec, "record fields")
        end
        rw(1'b0, STRES_OFF_CTRL, 32'h0);
        `CHK(r, 32'(1 << STRES_SRC_RUNTIME), "last source")
        rw(1'b1, STRES_OFF_RECORD, 32'h0);
        `CHK({e, diag_record}, {1'b1, exp_rec}, "record write refused")
        rw(1'b1, STRES_OFF_READCMD, 32'h1);
        `CHK(r[15:0], exp_rec, "read command data")
        `CHK({diag_read_done, diag_record}, {1'b1, 16'h0000}, "read done pulse")
        rw(1'b0, STRES_OFF_RECORD, 32'h0);
        `CHK(r, 32'h0, "record after read")
        rw(1'b0, 12'h0f0, 32'h0);
        `CHK({e, r}, {1'b1, 32'h0}, "unmapped read")
        $display("record test done");
        report_and_stop();
    end
endmodule : testbench
